// [hw/wdtc_counter.sv]
// Purpose: Time-out counter stepped by watchdog oscillator ticks
// Assumes: tick is already synchronised to clock and lasts one cycle
// Notes:   expire is a registered one-cycle pulse
`timescale 1ns/10ps
`include "wdtc_defines.svh"

module wdtc_counter #(
  parameter int CNT_W = 20
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             tick,
  input  wire logic             clear,
  input  wire logic             run,
  input  wire logic [3:0]       sel,
  output logic                  expire
);

  // Longest period must fit in the counter
  if (CNT_W < `WDTC_BASE_LOG2 + `WDTC_SEL_MAX) begin : g_badWidth
    $error("wdtc_counter: CNT_W too small");
  end

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             expire;
  } wdtc_cnt_state_s;

  wdtc_cnt_state_s s_r;
  wdtc_cnt_state_s s_nxt;
  logic [CNT_W:0]  limit;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.expire = 1'b0;
    limit = (CNT_W+1)'((CNT_W+1)'(1) << (`WDTC_BASE_LOG2 + int'(sel))) - (CNT_W+1)'(1); // [RL2]
    if (clear || !run) begin
      s_nxt.count = '0;
    end else if (tick) begin
      if ({1'b0, s_r.count} == limit) begin
        s_nxt.count  = '0;
        s_nxt.expire = 1'b1;
      end else begin
        s_nxt.count = s_r.count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expire = s_r.expire;

endmodule : wdtc_counter

// [hw/wdtc_defines.svh]
// Purpose: Offsets, field positions and timing counts of the watchdog configuration block
// Assumes: APB byte addresses, 32-bit data, 8-bit control word in the low bits
// Notes:   Definitions only
`ifndef WDTC_DEFINES_SVH
`define WDTC_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define WDTC_ADDR_W        12
`define WDTC_OFS_CTRL      12'h000
`define WDTC_OFS_CAUSE     12'h004
`define WDTC_OFS_KICK      12'h008

// ****************************************
// Control word and cause register fields
// ****************************************
`define WDTC_BIT_IRQF      7
`define WDTC_BIT_IRQE      6
`define WDTC_BIT_SEL3      5
`define WDTC_BIT_UNLOCK    4
`define WDTC_BIT_EN        3
`define WDTC_CAUSE_RSTF    3

// ****************************************
// Counts and constants
// ****************************************
`define WDTC_UNLOCK_CYC    3'h4
`define WDTC_UNLOCK_NONE   3'h0
`define WDTC_SEL_MAX       4'h9
`define WDTC_BASE_LOG2     11
`define WDTC_RESET_VECTOR  16'h0000
`define WDTC_START_WAIT    2'h3

`endif

// [hw/wdtc_pkg.sv]
// Purpose: Types shared by the watchdog configuration block
// Assumes: wdtc_defines.svh gives the APB address width; other widths are fixed here
// Notes:   Bus request and response travel as packed structs
`include "wdtc_defines.svh"

package wdtc_pkg;

  typedef struct packed {
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [`WDTC_ADDR_W-1:0]  paddr;
    logic [31:0]              pwdata;
  } wdtc_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wdtc_apb_rsp_s;

  typedef enum logic {
    WDTC_LVL1,
    WDTC_LVL2
  } wdtc_level_e;

  typedef struct packed {
    wdtc_apb_rsp_s rsp;
    logic [1:0]    oscSync;
    logic          oscPrev;
    logic [1:0]    fuseSync;
    logic [1:0]    startCnt;
    logic          lvlValid;
    wdtc_level_e   level;
    logic [2:0]    window;
    logic          en;
    logic          irqEn;
    logic          irqFlag;
    logic [3:0]    sel;
    logic          rstFlag;
    logic          irqOut;
    logic          sysRst;
    logic [15:0]   resetVector;
  } wdtc_state_s;

endpackage : wdtc_pkg

// [hw/wdtc_top.sv]
// Purpose: Watchdog configuration, timed unlock and time-out action over APB
// Assumes: wdOsc is the free-running watchdog oscillator, far slower than clock
// Notes:   One wait state on every APB access
//
// How it works
// RL1 - While running, the time-out interval follows the four-bit select field.
// RL2 - Counts oscillator cycles, 2K doubling per code up to 1024K.
// RL3 - Reserved select codes from 1010 upward fall back to a valid setting.
// RL4 - Level 1 starts disabled; writing enable one enables with no unlock.
// RL5 - Level 1 disable starts with unlock and enable written one together.
// RL6 - Then within four cycles software writes enable and select, unlock zero.
// RL7 - Protected writes count only within four cycles after the unlock write.
// RL8 - Level 2 always runs; enable reads back as one.
// RL9 - Level 2 period change starts with unlock and enable written one.
// RL10 - Level 2 second write changes only select; enable value ignored.
// RL11 - Software writes back the old select in the unlock write.
// RL12 - Watchdog reset restarts at program address zero.
// RL13 - Unlock bit clears itself four cycles after being written.
// RL14 - Time-out gives interrupt if irq enable, reset if only enable.
// RL15 - Level 1 enable is forced on while the reset flag is set.
// RL16 - With both enables set, a time-out clears irq enable.
// RL17 - Safety level is a fuse input captured once after reset.
// RL18 - Oscillator events pass a synchroniser before touching flags.
`timescale 1ns/10ps
`include "wdtc_defines.svh"

module wdtc_top #(
  parameter int CNT_W = 20
) (
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  input  wdtc_pkg::wdtc_apb_req_s     apbReq,
  output wdtc_pkg::wdtc_apb_rsp_s     apbRsp,
  input  wire logic                   wdOsc,
  input  wire logic                   alwaysOnFuse,
  input  wire logic                   irqAck,
  output logic                        timeoutIrq,
  output logic                        sysReset,
  output logic [15:0]                 resetVector
);

  // ****************************************
  // State
  // ****************************************
  wdtc_pkg::wdtc_state_s s_r;
  wdtc_pkg::wdtc_state_s s_nxt;
  logic                  tick;
  logic                  expire;
  logic                  cntClear;

  // ****************************************
  // Parameter check
  // ****************************************
  // A narrower counter would wrap before the longest period ends
  if (CNT_W < `WDTC_BASE_LOG2 + `WDTC_SEL_MAX) begin : g_badWidth
    $error("wdtc_top: CNT_W too small");
  end

  // Reserved codes use the longest valid period
  function automatic logic [3:0] effSel(input logic [3:0] sel);
    effSel = (sel > `WDTC_SEL_MAX) ? `WDTC_SEL_MAX : sel; // [RL3]
  endfunction : effSel

  function automatic logic [7:0] ctrlWord(input wdtc_pkg::wdtc_state_s s);
    ctrlWord = {s.irqFlag, s.irqEn, s.sel[3], (s.window != `WDTC_UNLOCK_NONE), s.en,
                s.sel[2:0]};
  endfunction : ctrlWord

  // Select field is split around the unlock and enable bits
  function automatic logic [3:0] wrSel(input logic [7:0] w);
    wrSel = {w[`WDTC_BIT_SEL3], w[2:0]};
  endfunction : wrSel

  // ****************************************
  // Next state
  // ****************************************
  logic       access;
  logic       wrCommit;
  logic       lvl2;
  logic       inWin;
  logic       unlockReq;
  logic       protWr;
  logic [7:0] d;

  always_comb begin
    s_nxt            = s_r;
    // Response fields stand for one cycle only
    s_nxt.rsp        = '0;
    s_nxt.sysRst     = 1'b0;
    cntClear         = 1'b0;
    // ****************************************
    // Synchronisers and level capture
    // ****************************************
    // Osc edge only seen after two flops
    s_nxt.oscSync    = {s_r.oscSync[0], wdOsc}; // [RL18]
    s_nxt.oscPrev    = s_r.oscSync[1];
    tick             = s_r.oscSync[1] & ~s_r.oscPrev; // [RL18]
    s_nxt.fuseSync   = {s_r.fuseSync[0], alwaysOnFuse};
    // Fuse caught once, after the synchroniser has filled
    if (!s_r.lvlValid) begin
      if (s_r.startCnt == `WDTC_START_WAIT) begin
        s_nxt.lvlValid = 1'b1; // [RL17]
        s_nxt.level = s_r.fuseSync[1] ? wdtc_pkg::WDTC_LVL2 : wdtc_pkg::WDTC_LVL1; // [RL17]
      end else begin
        s_nxt.startCnt = s_r.startCnt + 2'h1;
      end
    end
    // ****************************************
    // Unlock window
    // ****************************************
    // Back-to-back transfers put the protected commit three edges after the unlock
    lvl2 = s_r.lvlValid && (s_r.level == wdtc_pkg::WDTC_LVL2);
    inWin = (s_r.window != `WDTC_UNLOCK_NONE);
    if (inWin) begin
      s_nxt.window = s_r.window - 3'h1; // [RL13]
    end
    // ****************************************
    // APB slave
    // ****************************************
    access   = apbReq.psel & apbReq.penable;
    wrCommit = access & s_r.rsp.pready & apbReq.pwrite;
    d        = apbReq.pwdata[7:0];
    unlockReq = d[`WDTC_BIT_UNLOCK] & d[`WDTC_BIT_EN]; // [RL5] [RL9]
    protWr   = inWin & ~d[`WDTC_BIT_UNLOCK]; // [RL7]
    // Read data show the state at the first access edge
    if (access && !s_r.rsp.pready) begin
      s_nxt.rsp.pready  = 1'b1;
      s_nxt.rsp.pslverr = 1'b0;
      s_nxt.rsp.prdata  = '0;
      case (apbReq.paddr)
        `WDTC_OFS_CTRL:  s_nxt.rsp.prdata[7:0] = ctrlWord(s_r);
        `WDTC_OFS_CAUSE: s_nxt.rsp.prdata[`WDTC_CAUSE_RSTF] = s_r.rstFlag;
        `WDTC_OFS_KICK:  s_nxt.rsp.prdata = '0;
        default:         s_nxt.rsp.pslverr = 1'b1;
      endcase
    end
    if (wrCommit) begin
      case (apbReq.paddr)
        `WDTC_OFS_CTRL: begin
          cntClear = 1'b1;
          if (d[`WDTC_BIT_IRQF]) begin
            s_nxt.irqFlag = 1'b0;
          end
          s_nxt.irqEn = d[`WDTC_BIT_IRQE];
          if (unlockReq) begin
            s_nxt.window = `WDTC_UNLOCK_CYC; // [RL7]
          end
          if (!lvl2) begin
            s_nxt.sel = wrSel(d);
            if (d[`WDTC_BIT_EN]) begin
              s_nxt.en = 1'b1; // [RL4]
            end else if (protWr) begin
              s_nxt.en = 1'b0; // [RL6] [RL7]
            end
          end else if (protWr) begin
            s_nxt.sel = wrSel(d); // [RL10]
          end
          if (protWr) begin
            s_nxt.window = `WDTC_UNLOCK_NONE;
          end
        end
        `WDTC_OFS_CAUSE: s_nxt.rstFlag = s_r.rstFlag & d[`WDTC_CAUSE_RSTF];
        `WDTC_OFS_KICK:  cntClear = 1'b1;
        default:         cntClear = cntClear;
      endcase
    end
    if (irqAck) begin
      s_nxt.irqFlag = 1'b0;
    end
    // ****************************************
    // Time-out action; events win over clears
    // ****************************************
    if (expire) begin
      if (s_r.irqEn) begin
        s_nxt.irqFlag = 1'b1; // [RL14]
        if (s_r.en) begin
          s_nxt.irqEn = 1'b0; // [RL16]
        end
      end else if (s_r.en) begin
        s_nxt.sysRst  = 1'b1; // [RL14]
        s_nxt.rstFlag = 1'b1;
      end
    end
    // ****************************************
    // Enable overrides
    // ****************************************
    // A pending reset flag keeps enable up so a failing loop keeps resetting
    s_nxt.en = s_nxt.en | lvl2 | (s_nxt.lvlValid & s_nxt.level == wdtc_pkg::WDTC_LVL2)
               | s_nxt.rstFlag; // [RL8] [RL15]
    // Once raised the request stays until the flag clears, even after irq enable
    // clears itself; a watchdog reset supersedes it
    s_nxt.irqOut      = s_nxt.irqFlag & ~s_nxt.sysRst
                        & (s_nxt.irqEn | s_r.irqOut | (expire & s_r.irqEn)); // [RL14] [RL16]
    s_nxt.resetVector = `WDTC_RESET_VECTOR; // [RL12]
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  // Any control write restarts the count, so a rewrite doubles as a kick
  wdtc_counter #(
    .CNT_W (CNT_W)
  ) u_counter (
    .clock  (clock),
    .arst_n (arst_n),
    .tick   (tick),
    .clear  (cntClear | s_r.sysRst),
    .run    (s_r.en | s_r.irqEn), // [RL1]
    .sel    (effSel(s_r.sel)), // [RL1] [RL3]
    .expire (expire)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign apbRsp      = s_r.rsp;
  assign timeoutIrq  = s_r.irqOut;
  assign sysReset    = s_r.sysRst;
  assign resetVector = s_r.resetVector;

endmodule : wdtc_top

// [verification/wdtc_properties.sv]
// Purpose: Port checks for the watchdog configuration block
// Assumes: Control is read only after the fuse has settled
// Notes:   Bound to wdtc_top below
`timescale 1ns/10ps

module wdtc_properties #(
  parameter int CNT_W = 20
) (
  input logic                    clock,
  input logic                    arst_n,
  input wdtc_pkg::wdtc_apb_req_s apbReq,
  input wdtc_pkg::wdtc_apb_rsp_s apbRsp,
  input logic                    wdOsc,
  input logic                    alwaysOnFuse,
  input logic                    irqAck,
  input logic                    timeoutIrq,
  input logic                    sysReset,
  input logic [15:0]             resetVector
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_acc;
    apbReq.psel && apbReq.penable && !apbRsp.pready;
  endsequence
  sequence s_ctlRd;
    apbRsp.pready && !apbReq.pwrite && apbReq.paddr == 12'h000 && !apbRsp.pslverr;
  endsequence
  property p_wait; s_acc |=> apbRsp.pready; endproperty
  property p_once; apbRsp.pready |=> !apbRsp.pready; endproperty
  property p_err; apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == 32'h0; endproperty
  property p_lvl2; s_ctlRd and alwaysOnFuse |-> apbRsp.prdata[3]; endproperty
  property p_vec; resetVector == 16'h0000; endproperty
  property p_pulse; sysReset |=> !sysReset; endproperty
  property p_act; sysReset |-> !timeoutIrq; endproperty
  // Expiry must cross the synchroniser, so no reaction right after a tick
  property p_sync; $rose(wdOsc) |=> !sysReset [*2]; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  a_once: assert property (p_once) else $error("pready too long");
  a_err: assert property (p_err) else $error("bad error answer");
  a_lvl2: assert property (p_lvl2) else $error("enable low in level 2");
  a_vec: assert property (p_vec) else $error("reset vector not zero");
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  a_act: assert property (p_act) else $error("reset with interrupt");
  a_sync: assert property (p_sync) else $error("unsynchronised expiry");
endmodule : wdtc_properties

bind wdtc_top wdtc_properties #(.CNT_W(CNT_W)) u_props (.clock(clock), .arst_n(arst_n),
  .apbReq(apbReq), .apbRsp(apbRsp), .wdOsc(wdOsc), .alwaysOnFuse(alwaysOnFuse),
  .irqAck(irqAck), .timeoutIrq(timeoutIrq), .sysReset(sysReset), .resetVector(resetVector));

// [verification/wdtc_top_tb_top.sv]
// Purpose: Self-checking bench for the watchdog configuration block
// Assumes: Oscillator ticks every 8 clocks to keep time-outs short
// Notes:   Reads queue their expected word; a monitor compares
`timescale 1ns/10ps

module wdtc_top_tb_top;
  logic                    clock = 1'b0;
  logic                    arst_n = 1'b0;
  wdtc_pkg::wdtc_apb_req_s req = '0;
  wdtc_pkg::wdtc_apb_rsp_s rsp;
  logic [2:0]              oscCnt = 3'h0;
  logic                    fuse = 1'b0;
  logic                    irqAck = 1'b0;
  logic                    irq;
  logic                    sysRst;
  logic [15:0]             vec;
  logic [32:0]             expQ[$];
  int                      errors = 0;
  int                      n_checks = 0;
  int                      k;
  logic [7:0]              d;

  wdtc_top u_dut (.clock(clock), .arst_n(arst_n), .apbReq(req), .apbRsp(rsp),
    .wdOsc(oscCnt[2]), .alwaysOnFuse(fuse), .irqAck(irqAck), .timeoutIrq(irq),
    .sysReset(sysRst), .resetVector(vec));

  // ****
  // Tasks
  // ****
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) oscCnt <= oscCnt + 3'h1;

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Request is held until pready; release is left to idle so transfers chain
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v,
                     input logic [32:0] e);
    int n;
    if (!w) expQ.push_back(e);
    req <= '{1'b1, 1'b0, w, a, {24'h0, v}};
    @(posedge clock);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      errors++;
      give_verdict();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, v, 33'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] v);
    apb(1'b0, a, 8'h00, {25'h0, v});
  endtask : rd

  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clock);
  endtask : idle

  task automatic rst(input logic f);
    req <= '0;
    fuse <= f;
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask : rst

  // Tolerance covers oscillator phase plus synchroniser delay
  task automatic waitHi(input logic isIrq, input int cyc);
    for (k = 0; k < cyc + 20 && (isIrq ? irq : sysRst) !== 1'b1; k++) @(posedge clock);
    chk({32'h0, k > cyc - 20 && k < cyc + 20}, 33'h1);
    if (k >= cyc + 20) give_verdict();
  endtask : waitHi

  always @(posedge clock) begin
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite && expQ.size() > 0) begin
      chk({rsp.pslverr, rsp.prdata}, expQ.pop_front());
    end
  end

  // ****
  // Scenarios
  // ****
  initial begin
    k = $urandom(79658);
    rst(1'b0);
    rd(12'h000, 8'h00);
    apb(1'b0, 12'hFFC, 8'h00, {1'b1, 32'h0});
    repeat (3) begin
      k = $urandom_range(9);
      d = 8'h08 | {2'b0, k[3], 2'b0, k[2:0]};
      wr(12'h000, d);
      rd(12'h000, d);
    end
    wr(12'h000, d | 8'h18);
    wr(12'h000, 8'h00);
    rd(12'h000, 8'h00);
    wr(12'h000, 8'h0A);
    wr(12'h000, 8'h1A);
    idle(6);
    wr(12'h000, 8'h02);
    rd(12'h000, 8'h0A);
    wr(12'h000, 8'h09);
    idle(1);
    waitHi(1'b0, 32768);
    rd(12'h004, 8'h08);
    wr(12'h000, 8'h19);
    wr(12'h000, 8'h01);
    rd(12'h000, 8'h09);
    wr(12'h004, 8'h00);
    wr(12'h000, 8'h19);
    wr(12'h000, 8'h01);
    rd(12'h000, 8'h01);
    wr(12'h000, 8'h40);
    idle(1);
    waitHi(1'b1, 16384);
    rd(12'h000, 8'hC0);
    irqAck <= 1'b1;
    idle(1);
    irqAck <= 1'b0;
    rd(12'h000, 8'h40);
    wr(12'h000, 8'h48);
    idle(16420);
    chk({32'h0, irq}, 33'h1);
    rd(12'h000, 8'h88);
    wr(12'h000, 8'hE7);
    idle(17000);
    rd(12'h000, 8'h6F);
    chk({17'h0, vec}, 33'h0);
    rst(1'b1);
    rd(12'h000, 8'h08);
    wr(12'h000, 8'h00);
    rd(12'h000, 8'h08);
    wr(12'h000, 8'h18);
    wr(12'h000, 8'h03);
    rd(12'h000, 8'h0B);
    idle(4);
    give_verdict();
  end
endmodule : wdtc_top_tb_top
